//--- hw/dsd_decoder.sv
// Notes on behaviour
// - Registers, I/O, extended I/O, then SRAM
// - SRAM follows extended I/O, sized per variant
// - Direct address reaches the whole data space
// - Y or Z base plus 0..63 offset
// - Pointer written back after decrement or increment
// - SRAM access takes two clock cycles
// - Short I/O uses 0x00-0x3F, plus 0x20 otherwise
// - Extended I/O only by load and store
// - Bit ops and skips on I/O 0x00-0x1F
// - Bit ops write only the addressed bit
// - Status flags clear on written one
// - Three general purpose I/O registers
// - Separate byte-wide nonvolatile store
// - Store registers live in I/O space
// - Store read stalls four cycles
// - Store write start stalls two cycles
// - Self-timed writes with pollable busy
// - Reset lets a running write finish
// - Arm clears after four cycles; start needs it
`include "dsd_regs.svh"
`timescale 1ns/10ps
module dsd_decoder #(
    parameter int SRAM_BYTES = `DSD_SRAM_BYTES,
    parameter int NV_BYTES = `DSD_NV_BYTES,
    parameter int NV_ATOM_CYC = `DSD_NV_ATOM_CYC,
    parameter int NV_HALF_CYC = `DSD_NV_HALF_CYC
) (
    // Clock, enable, resets
    input wire logic CLK,
    input wire logic CE,
    input wire logic SYS_RST,
    input wire logic NV_POR,
    // Core request
    input wire logic REQ_VALID,
    output logic REQ_READY,
    input dsd_pkg::dsd_kind_t REQ_KIND,
    input dsd_pkg::dsd_mode_t REQ_MODE,
    input dsd_pkg::dsd_ptr_t REQ_PTR,
    input wire logic [15:0] REQ_ADDR,
    input wire logic [5:0] REQ_DISP,
    input wire logic [2:0] REQ_BIT,
    input wire logic [7:0] REQ_WDATA,
    input wire logic [15:0] PTR_X,
    input wire logic [15:0] PTR_Y,
    input wire logic [15:0] PTR_Z,
    // Core response
    output logic RSP_VALID,
    output logic [7:0] RSP_DATA,
    output logic RSP_SKIP,
    output logic PTR_WB_VALID,
    output dsd_pkg::dsd_ptr_t PTR_WB_SEL,
    output logic [15:0] PTR_WB_VALUE,
    // Register file port
    output logic [4:0] RF_ADDR,
    output logic RF_WE,
    output logic [7:0] RF_WDATA,
    input wire logic [7:0] RF_RDATA,
    // Peripheral I/O port
    output logic [7:0] IO_ADDR,
    output logic IO_RE,
    output logic IO_WE,
    output logic [7:0] IO_WMASK,
    output logic [7:0] IO_WDATA,
    input wire logic [7:0] IO_RDATA,
    // Status flag events and store status
    input wire logic [7:0] FLAG_SET,
    output logic NV_BUSY
);
    localparam int SW = $clog2(SRAM_BYTES);
    localparam int AW = $clog2(NV_BYTES);
    localparam logic [15:0] SRAM_END = 16'(`DSD_SRAM_BASE + SRAM_BYTES);
    localparam logic [5:0] GP_IO [3] = '{`DSD_IO_GP0, `DSD_IO_GP1,
                                         `DSD_IO_GP2};
    dsd_nv_if #(.ADDR_W(AW)) nv ();
    dsd_nv_store #(.BYTES(NV_BYTES), .ADDR_W(AW), .CYC_ATOM(NV_ATOM_CYC),
        .CYC_HALF(NV_HALF_CYC)) u_store (.clk(CLK), .ce(CE), .por(NV_POR),
        .nv(nv.ctl));
    // ***************************************************
    // Request capture and address computation
    // ***************************************************
    dsd_pkg::dsd_state_t state;
    logic [2:0] stall_cnt;
    logic take, io_kind;
    logic [15:0] base, next_addr;
    dsd_pkg::dsd_kind_t acc_kind;
    logic [15:0] acc_addr;
    logic [7:0] acc_wdata;
    logic [2:0] acc_bit;
    assign REQ_READY = (state == dsd_pkg::S_IDLE);
    assign take = CE && REQ_VALID && REQ_READY;
    assign io_kind = !(REQ_KIND inside {dsd_pkg::K_LOAD, dsd_pkg::K_STORE});
    always_comb begin
        case (REQ_PTR)
            dsd_pkg::P_Y: base = PTR_Y;
            dsd_pkg::P_Z: base = PTR_Z;
            default: base = PTR_X;
        endcase
        if (io_kind) begin
            // Short I/O numbers sit 0x20 above in data space
            next_addr = {10'h000, REQ_ADDR[5:0]} + `DSD_IO_LD_OFS;
        end else begin
            case (REQ_MODE)
                dsd_pkg::M_DIRECT: next_addr = REQ_ADDR;
                // X has no displacement form
                dsd_pkg::M_DISP: next_addr = (REQ_PTR == dsd_pkg::P_X) ?
                    base : base + {10'h000, REQ_DISP};
                dsd_pkg::M_PREDEC: next_addr = base - 16'h0001;
                default: next_addr = base;
            endcase
        end
    end
    always_ff @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            acc_kind <= dsd_pkg::K_LOAD;
            acc_addr <= 16'h0000;
            acc_wdata <= 8'h00;
            acc_bit <= 3'h0;
        end else if (take) begin
            acc_kind <= REQ_KIND;
            acc_addr <= next_addr;
            acc_wdata <= REQ_WDATA;
            acc_bit <= REQ_BIT;
        end
    end
    always_ff @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            PTR_WB_VALID <= 1'b0;
            PTR_WB_SEL <= dsd_pkg::P_X;
            PTR_WB_VALUE <= 16'h0000;
        end else if (CE) begin
            PTR_WB_VALID <= take && !io_kind &&
                (REQ_MODE inside {dsd_pkg::M_PREDEC, dsd_pkg::M_POSTINC});
            if (take) begin
                PTR_WB_SEL <= REQ_PTR;
                PTR_WB_VALUE <= (REQ_MODE == dsd_pkg::M_POSTINC) ?
                    base + 16'h0001 : base - 16'h0001;
            end
        end
    end
    // ***************************************************
    // Access cycle decode
    // ***************************************************
    logic in_acc, is_bit, bit_ok, do_wr, do_bit, do_rd, is_skip, io_wr;
    logic hit_rf, hit_io, hit_ext, hit_sram, int_hit, ext_sel;
    logic [15:0] io_full, sram_off;
    logic [5:0] io_idx;
    logic [7:0] mask, rd_byte, ctl_view, new_ctl;
    assign in_acc = CE && (state == dsd_pkg::S_ACCESS);
    assign is_bit = acc_kind inside {dsd_pkg::K_BSET, dsd_pkg::K_BCLR};
    assign is_skip = acc_kind inside {dsd_pkg::K_SKIP_SET,
                                      dsd_pkg::K_SKIP_CLR};
    assign bit_ok = acc_addr < `DSD_BIT_IO_END;
    assign mask = 8'h01 << acc_bit;
    assign do_wr = in_acc &&
        (acc_kind inside {dsd_pkg::K_STORE, dsd_pkg::K_OUT});
    assign do_bit = in_acc && is_bit && bit_ok;
    assign do_rd = in_acc && ((is_skip && bit_ok) ||
        (acc_kind inside {dsd_pkg::K_LOAD, dsd_pkg::K_IN}));
    // Region order in data space
    assign hit_rf = acc_addr < `DSD_IO_BASE;
    assign hit_io = !hit_rf && (acc_addr < `DSD_EXT_BASE);
    assign hit_ext = !hit_rf && !hit_io && (acc_addr < `DSD_SRAM_BASE);
    assign hit_sram = (acc_addr >= `DSD_SRAM_BASE) &&
                      (acc_addr < SRAM_END);
    assign io_full = acc_addr - `DSD_IO_LD_OFS;
    assign io_idx = io_full[5:0];
    assign sram_off = acc_addr - `DSD_SRAM_BASE;
    assign io_wr = (do_wr || do_bit) && hit_io;
    assign int_hit = hit_io && (io_idx inside {`DSD_IO_FLAGS, `DSD_IO_NVCTL,
        `DSD_IO_NVDAT, `DSD_IO_NVADL, `DSD_IO_NVADH, `DSD_IO_GP0,
        `DSD_IO_GP1, `DSD_IO_GP2});
    assign ext_sel = (hit_io && !int_hit) || hit_ext;
    // Bit ops change one bit and leave the rest as stored
    function automatic logic [7:0] upd(input logic [7:0] old);
        if (!is_bit) upd = acc_wdata;
        else if (acc_kind == dsd_pkg::K_BSET) upd = old | mask;
        else upd = old & ~mask;
    endfunction
    // ***************************************************
    // Internal I/O registers
    // ***************************************************
    logic [7:0] flags, nv_dat, gp [3], adh_new, flg_clr;
    logic [AW-1:0] nv_addr;
    logic arm, rdy_en, wr_ctl, nv_start, nv_read;
    logic [2:0] arm_cnt;
    dsd_pkg::dsd_nvmode_t nv_mode, mode_view;
    assign wr_ctl = io_wr && io_idx == `DSD_IO_NVCTL;
    assign mode_view = nv.busy ? nv.eng_mode : nv_mode;
    // Read strobe reads back zero; start bit shows busy
    assign ctl_view = {2'b00, mode_view, rdy_en, arm, nv.busy, 1'b0};
    assign new_ctl = upd(ctl_view);
    // Start commits only while armed
    assign nv_start = wr_ctl && new_ctl[`DSD_NVCTL_START] && arm &&
                      !nv.busy;
    assign nv_read = wr_ctl && new_ctl[`DSD_NVCTL_RD] && !nv.busy &&
                     !nv_start;
    assign adh_new = upd(8'(nv_addr >> 8));
    for (genvar g = 0; g < 3; g++) begin : gen_gp
        always_ff @(posedge CLK or posedge SYS_RST) begin
            if (SYS_RST) gp[g] <= `DSD_BYTE_RST;
            else if (io_wr && io_idx == GP_IO[g])
                gp[g] <= upd(gp[g]);
        end
    end
    // Events win over a clear in the same cycle
    assign flg_clr = (io_wr && io_idx == `DSD_IO_FLAGS) ? (is_bit ?
        (acc_kind == dsd_pkg::K_BSET ? mask : 8'h00) : acc_wdata) :
        8'h00;
    always_ff @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) flags <= `DSD_BYTE_RST;
        else if (CE) flags <= (flags & ~flg_clr) | FLAG_SET;
    end
    // Arm stays up while its counter runs: four cycles
    assign arm = arm_cnt != 3'h0;
    always_ff @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) arm_cnt <= 3'h0;
        else if (CE && wr_ctl && new_ctl[`DSD_NVCTL_ARM] && !arm)
            arm_cnt <= `DSD_ARM_CYCLES;
        else if (CE && arm) arm_cnt <= arm_cnt - 3'h1;
    end
    // Mode writes are ignored while a write runs
    always_ff @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            nv_mode <= dsd_pkg::NV_ATOMIC;
            rdy_en <= 1'b0;
        end else if (wr_ctl) begin
            rdy_en <= new_ctl[`DSD_NVCTL_RDYEN];
            if (!nv.busy) nv_mode <= dsd_pkg::dsd_nvmode_t'(
                new_ctl[`DSD_NVCTL_MODE_HI:`DSD_NVCTL_MODE_LO]);
        end
    end
    // Address frozen during a write; data loaded by a read
    always_ff @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            nv_addr <= '0;
            nv_dat <= `DSD_BYTE_RST;
        end else if (CE) begin
            if (io_wr && !nv.busy && io_idx == `DSD_IO_NVADL)
                nv_addr[7:0] <= upd(nv_addr[7:0]);
            if (io_wr && !nv.busy && io_idx == `DSD_IO_NVADH)
                nv_addr[AW-1:8] <= adh_new[AW-9:0];
            if (nv_read) nv_dat <= nv.rdata;
            else if (io_wr && io_idx == `DSD_IO_NVDAT) nv_dat <= upd(nv_dat);
        end
    end
    assign nv.wr_req = nv_start && CE;
    assign nv.addr = nv_addr;
    assign nv.wdata = nv_dat;
    assign nv.mode = nv_mode;
    assign NV_BUSY = nv.busy;
    // ***************************************************
    // Read path and ports
    // ***************************************************
    logic [7:0] sram [SRAM_BYTES];
    always_comb begin
        rd_byte = 8'h00;
        if (hit_rf) rd_byte = RF_RDATA;
        else if (hit_sram) rd_byte = sram[sram_off[SW-1:0]];
        else if (ext_sel) rd_byte = IO_RDATA;
        else if (int_hit) begin
            case (io_idx)
                `DSD_IO_FLAGS: rd_byte = flags;
                `DSD_IO_NVCTL: rd_byte = ctl_view;
                `DSD_IO_NVDAT: rd_byte = nv_dat;
                `DSD_IO_NVADL: rd_byte = nv_addr[7:0];
                `DSD_IO_NVADH: rd_byte = 8'(nv_addr >> 8);
                default: rd_byte = 8'h00;
            endcase
            for (int i = 0; i < 3; i++) begin
                if (io_idx == GP_IO[i]) rd_byte = gp[i];
            end
        end
    end
    // SRAM data moves in the second cycle
    always_ff @(posedge CLK) begin
        if (do_wr && hit_sram) sram[sram_off[SW-1:0]] <= acc_wdata;
    end
    assign RF_ADDR = acc_addr[4:0];
    assign RF_WE = do_wr && hit_rf;
    assign RF_WDATA = acc_wdata;
    assign IO_ADDR = acc_addr[7:0];
    assign IO_RE = do_rd && ext_sel;
    assign IO_WE = (do_wr || do_bit) && ext_sel;
    assign IO_WMASK = do_bit ? mask : 8'hff;
    assign IO_WDATA = do_bit ?
        (acc_kind == dsd_pkg::K_BSET ? mask : 8'h00) : acc_wdata;
    always_ff @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            RSP_VALID <= 1'b0;
            RSP_DATA <= 8'h00;
            RSP_SKIP <= 1'b0;
        end else if (CE) begin
            RSP_VALID <= in_acc;
            if (in_acc) begin
                RSP_DATA <= do_rd ? rd_byte : 8'h00;
                RSP_SKIP <= is_skip && bit_ok && (rd_byte[acc_bit] ==
                    (acc_kind == dsd_pkg::K_SKIP_SET));
            end
        end
    end
    // ***************************************************
    // Sequencer
    // ***************************************************
    always_ff @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            state <= dsd_pkg::S_IDLE;
            stall_cnt <= 3'h0;
        end else if (CE) begin
            case (state)
                dsd_pkg::S_IDLE: if (take) state <= dsd_pkg::S_ACCESS;
                dsd_pkg::S_ACCESS: begin
                    state <= dsd_pkg::S_IDLE;
                    if (nv_read) begin
                        state <= dsd_pkg::S_NVWAIT;
                        stall_cnt <= `DSD_NV_RD_STALL;
                    end else if (nv_start) begin
                        state <= dsd_pkg::S_NVWAIT;
                        stall_cnt <= `DSD_NV_WR_STALL;
                    end
                end
                dsd_pkg::S_NVWAIT: begin
                    stall_cnt <= stall_cnt - 3'h1;
                    if (stall_cnt == 3'h1) state <= dsd_pkg::S_IDLE;
                end
                default: state <= dsd_pkg::S_IDLE;
            endcase
        end
    end
endmodule

//--- hw/dsd_regs.svh
`ifndef DSD_REGS_SVH
`define DSD_REGS_SVH

// ***************************************************
// Data space map (data addresses)
// ***************************************************
`define DSD_RF_BASE 16'h0000
`define DSD_IO_BASE 16'h0020
`define DSD_EXT_BASE 16'h0060
`define DSD_SRAM_BASE 16'h0100
`define DSD_IO_LD_OFS 16'h0020
`define DSD_BIT_IO_END 16'h0040
`define DSD_SRAM_BYTES 512
`define DSD_NV_BYTES 512

// ***************************************************
// Internal I/O registers (I/O addresses)
// ***************************************************
`define DSD_IO_FLAGS 6'h15
`define DSD_IO_GP0 6'h1e
`define DSD_IO_NVCTL 6'h1f
`define DSD_IO_NVDAT 6'h20
`define DSD_IO_NVADL 6'h21
`define DSD_IO_NVADH 6'h22
`define DSD_IO_GP1 6'h2a
`define DSD_IO_GP2 6'h2b

// ***************************************************
// Nonvolatile control fields and reset values
// ***************************************************
`define DSD_NVCTL_RD 0
`define DSD_NVCTL_START 1
`define DSD_NVCTL_ARM 2
`define DSD_NVCTL_RDYEN 3
`define DSD_NVCTL_MODE_LO 4
`define DSD_NVCTL_MODE_HI 5
`define DSD_BYTE_RST 8'h00

// ***************************************************
// Timing
// ***************************************************
`define DSD_CLK_MHZ 50
`define DSD_ARM_CYCLES 3'h4
`define DSD_NV_RD_STALL 3'h4
`define DSD_NV_WR_STALL 3'h2
`define DSD_NV_ATOM_US 3400
`define DSD_NV_HALF_US 1800
`define DSD_NV_ATOM_CYC (`DSD_NV_ATOM_US * `DSD_CLK_MHZ)
`define DSD_NV_HALF_CYC (`DSD_NV_HALF_US * `DSD_CLK_MHZ)

`endif

//--- hw/dsd_pkg.sv
package dsd_pkg;

    typedef enum logic [2:0] {
        K_LOAD = 3'h0,
        K_STORE = 3'h1,
        K_IN = 3'h2,
        K_OUT = 3'h3,
        K_BSET = 3'h4,
        K_BCLR = 3'h5,
        K_SKIP_SET = 3'h6,
        K_SKIP_CLR = 3'h7
    } dsd_kind_t;

    typedef enum logic [2:0] {
        M_DIRECT = 3'h0,
        M_IND = 3'h1,
        M_DISP = 3'h2,
        M_PREDEC = 3'h3,
        M_POSTINC = 3'h4
    } dsd_mode_t;

    typedef enum logic [1:0] {
        P_X = 2'h0,
        P_Y = 2'h1,
        P_Z = 2'h2
    } dsd_ptr_t;

    typedef enum logic [1:0] {
        NV_ATOMIC = 2'h0,
        NV_ERASE = 2'h1,
        NV_WRITE = 2'h2,
        NV_RSVD = 2'h3
    } dsd_nvmode_t;

    typedef enum logic [2:0] {
        S_IDLE = 3'b001,
        S_ACCESS = 3'b010,
        S_NVWAIT = 3'b100
    } dsd_state_t;

endpackage

//--- hw/dsd_nv_if.sv
`timescale 1ns/10ps
interface dsd_nv_if #(parameter int ADDR_W = 9);
    logic wr_req;
    logic [ADDR_W-1:0] addr;
    logic [7:0] wdata;
    dsd_pkg::dsd_nvmode_t mode;
    logic [7:0] rdata;
    logic busy;
    dsd_pkg::dsd_nvmode_t eng_mode;

    modport ctl (
        output wr_req, addr, wdata, mode,
        input rdata, busy, eng_mode
    );
    modport eng (
        input wr_req, addr, wdata, mode,
        output rdata, busy, eng_mode
    );
endinterface

//--- hw/dsd_nv_store.sv
`timescale 1ns/10ps
module dsd_nv_store #(
    parameter int BYTES = 512,
    parameter int ADDR_W = 9,
    parameter int CYC_ATOM = 170000,
    parameter int CYC_HALF = 90000
) (
    // Clock and power-on reset
    input wire logic clk,
    input wire logic ce,
    input wire logic por,
    // Controller side
    dsd_nv_if.eng nv
);
    localparam int CW = $clog2(CYC_ATOM + 1);

    logic [7:0] mem [BYTES];
    logic busy;
    logic [CW-1:0] cnt;
    logic [ADDR_W-1:0] l_addr;
    logic [7:0] l_data;
    dsd_pkg::dsd_nvmode_t l_mode;
    logic done;

    assign done = busy && (cnt == '0);

    // Engine ignores the system reset so a started write finishes
    always_ff @(posedge clk or posedge por) begin
        if (por) begin
            busy <= 1'b0;
            cnt <= '0;
        end else if (ce) begin
            if (!busy && nv.wr_req) begin
                busy <= 1'b1;
                if (nv.mode == dsd_pkg::NV_ATOMIC) begin
                    cnt <= CW'(CYC_ATOM - 1);
                end else begin
                    cnt <= CW'(CYC_HALF - 1);
                end
            end else if (done) begin
                busy <= 1'b0;
            end else if (busy) begin
                cnt <= cnt - 1'b1;
            end
        end
    end

    always_ff @(posedge clk or posedge por) begin
        if (por) begin
            l_addr <= '0;
            l_data <= 8'h00;
            l_mode <= dsd_pkg::NV_ATOMIC;
        end else if (ce && !busy && nv.wr_req) begin
            l_addr <= nv.addr;
            l_data <= nv.wdata;
            l_mode <= nv.mode;
        end
    end

    // Byte-wide store, one byte per operation
    always_ff @(posedge clk) begin
        if (ce && done) begin
            case (l_mode)
                dsd_pkg::NV_ATOMIC: begin
                    mem[l_addr] <= l_data;
                end
                dsd_pkg::NV_ERASE: begin
                    mem[l_addr] <= 8'hff;
                end
                dsd_pkg::NV_WRITE: begin
                    mem[l_addr] <= mem[l_addr] & l_data;
                end
                default: begin
                    mem[l_addr] <= mem[l_addr];
                end
            endcase
        end
    end

    assign nv.rdata = mem[nv.addr];
    assign nv.busy = busy;
    assign nv.eng_mode = l_mode;
endmodule

//--- bench/dsd_decoder_asserts.sv
`timescale 1ns/10ps
// ********************
// Port checker
// ********************
module dsd_decoder_asserts (
    // Clock and request
    input wire logic CLK,
    input wire logic CE,
    input wire logic SYS_RST,
    input wire logic REQ_VALID,
    input wire logic REQ_READY,
    input dsd_pkg::dsd_kind_t REQ_KIND,
    input dsd_pkg::dsd_mode_t REQ_MODE,
    input dsd_pkg::dsd_ptr_t REQ_PTR,
    input wire logic [15:0] REQ_ADDR,
    input wire logic [15:0] PTR_X,
    input wire logic [15:0] PTR_Z,
    // Response and ports
    input wire logic RSP_VALID,
    input wire logic PTR_WB_VALID,
    input wire logic [15:0] PTR_WB_VALUE,
    input wire logic [4:0] RF_ADDR,
    input wire logic RF_WE,
    input wire logic [7:0] IO_ADDR,
    input wire logic IO_WE,
    input wire logic [7:0] IO_WMASK
);
    default clocking cb @(posedge CLK); endclocking
    default disable iff (SYS_RST);
    sequence s_take; CE && REQ_VALID && REQ_READY; endsequence
    sequence s_dir; s_take ##0 REQ_MODE == dsd_pkg::M_DIRECT; endsequence
    property p_busy; s_take |=> !REQ_READY; endproperty
    a_busy: assert property (p_busy) else $error("ready in access");
    property p_rsp; s_take |-> ##2 RSP_VALID; endproperty
    a_rsp: assert property (p_rsp) else $error("late answer");
    property p_wb; PTR_WB_VALID |=> RSP_VALID; endproperty
    a_wb: assert property (p_wb) else $error("write-back order");
    property p_inc;
        s_take ##0 REQ_MODE == dsd_pkg::M_POSTINC ##0 REQ_PTR == dsd_pkg::P_X
        |=> PTR_WB_VALID && PTR_WB_VALUE == $past(PTR_X) + 16'h0001;
    endproperty
    a_inc: assert property (p_inc) else $error("bad increment");
    property p_dec;
        s_take ##0 REQ_MODE == dsd_pkg::M_PREDEC ##0 REQ_PTR == dsd_pkg::P_Z
        |=> PTR_WB_VALID && PTR_WB_VALUE == $past(PTR_Z) - 16'h0001;
    endproperty
    a_dec: assert property (p_dec) else $error("bad decrement");
    property p_rf;
        s_dir ##0 REQ_KIND == dsd_pkg::K_STORE ##0 REQ_ADDR < 16'h0020
        |=> RF_WE && RF_ADDR == $past(REQ_ADDR[4:0]);
    endproperty
    a_rf: assert property (p_rf) else $error("register file map");
    property p_out;
        s_take ##0 REQ_KIND == dsd_pkg::K_OUT ##0 REQ_ADDR[5:0] < 6'h15
        |=> IO_WE && IO_ADDR == {2'h0, $past(REQ_ADDR[5:0])} + 8'h20;
    endproperty
    a_out: assert property (p_out) else $error("io offset");
    property p_mask;
        IO_WE && IO_WMASK != 8'hff |-> $onehot(IO_WMASK) && IO_ADDR < 8'h40;
    endproperty
    a_mask: assert property (p_mask) else $error("bit op mask");
endmodule

bind dsd_decoder dsd_decoder_asserts i_dsd_decoder_asserts (.CLK, .CE,
    .SYS_RST, .REQ_VALID, .REQ_READY, .REQ_KIND, .REQ_MODE, .REQ_PTR,
    .REQ_ADDR, .PTR_X, .PTR_Z, .RSP_VALID, .PTR_WB_VALID, .PTR_WB_VALUE,
    .RF_ADDR, .RF_WE, .IO_ADDR, .IO_WE, .IO_WMASK);

//--- bench/dsd_periph_model.sv
`timescale 1ns/10ps
// ********************
// Register file and peripheral stand-in
// ********************
module dsd_periph_model (
    // Clock
    input wire logic CLK,
    // Register file
    input wire logic [4:0] RF_ADDR,
    input wire logic RF_WE,
    input wire logic [7:0] RF_WDATA,
    output logic [7:0] RF_RDATA,
    // Peripherals
    input wire logic [7:0] IO_ADDR,
    input wire logic IO_WE,
    input wire logic [7:0] IO_WMASK,
    input wire logic [7:0] IO_WDATA,
    output logic [7:0] IO_RDATA
);
    logic [7:0] rf [32];
    logic [7:0] io [256];
    always_ff @(posedge CLK) begin
        if (RF_WE) begin
            rf[RF_ADDR] <= RF_WDATA;
        end
        if (IO_WE) begin
            io[IO_ADDR] <= (io[IO_ADDR] & ~IO_WMASK) | (IO_WDATA & IO_WMASK);
        end
    end
    assign RF_RDATA = rf[RF_ADDR];
    assign IO_RDATA = io[IO_ADDR];
endmodule

//--- bench/tb_dsd_decoder.sv
`timescale 1ns/10ps
// ********************
// Decoder bench
// ********************
module tb_dsd_decoder;
    logic CLK = 1'b0, CE = 1'b1, SYS_RST = 1'b1, NV_POR = 1'b1;
    logic REQ_VALID = 1'b0, REQ_READY, RSP_VALID, RSP_SKIP, PTR_WB_VALID;
    logic RF_WE, IO_RE, IO_WE, NV_BUSY, s;
    dsd_pkg::dsd_kind_t REQ_KIND = dsd_pkg::K_LOAD;
    dsd_pkg::dsd_mode_t REQ_MODE = dsd_pkg::M_DIRECT, md = dsd_pkg::M_DIRECT;
    dsd_pkg::dsd_ptr_t REQ_PTR = dsd_pkg::P_X, pt = dsd_pkg::P_X, PTR_WB_SEL;
    logic [15:0] REQ_ADDR = 16'h0000, PTR_X = 16'h0200, PTR_Y = 16'h0100;
    logic [15:0] PTR_Z = 16'h0140, PTR_WB_VALUE;
    logic [7:0] REQ_WDATA = 8'h00, FLAG_SET = 8'h00, RSP_DATA, RF_WDATA, q;
    logic [7:0] RF_RDATA, IO_ADDR, IO_WMASK, IO_WDATA, IO_RDATA;
    logic [5:0] REQ_DISP = 6'h00;
    logic [4:0] RF_ADDR;
    logic [2:0] REQ_BIT = 3'h0;
    int bad_count = 0, n_tests = 0, lo;
    always #10 CLK = ~CLK;
    dsd_decoder #(.NV_ATOM_CYC(20), .NV_HALF_CYC(10)) i_dsd_decoder (.CLK,
        .CE, .SYS_RST, .NV_POR, .REQ_VALID, .REQ_READY, .REQ_KIND, .REQ_MODE,
        .REQ_PTR, .REQ_ADDR, .REQ_DISP, .REQ_BIT, .REQ_WDATA, .PTR_X, .PTR_Y,
        .PTR_Z, .RSP_VALID, .RSP_DATA, .RSP_SKIP, .PTR_WB_VALID, .PTR_WB_SEL,
        .PTR_WB_VALUE, .RF_ADDR, .RF_WE, .RF_WDATA, .RF_RDATA, .IO_ADDR,
        .IO_RE, .IO_WE, .IO_WMASK, .IO_WDATA, .IO_RDATA, .FLAG_SET, .NV_BUSY);
    dsd_periph_model i_dsd_periph_model (.CLK, .RF_ADDR, .RF_WE, .RF_WDATA,
        .RF_RDATA, .IO_ADDR, .IO_WE, .IO_WMASK, .IO_WDATA, .IO_RDATA);
    task automatic c8(input logic [7:0] g, input logic [7:0] e);
        n_tests++;
        if (g !== e) begin
            bad_count++;
            $display("BAD %0t got %h want %h", $time, g, e);
        end
    endtask
    task automatic cn(input int g, input int e);
        n_tests++;
        if (g != e) begin
            bad_count++;
            $display("BAD %0t cycles %0d want %0d", $time, g, e);
        end
    endtask
    // Held until taken; lo counts cycles until ready returns
    task automatic rq(input dsd_pkg::dsd_kind_t k, input logic [15:0] a,
            input logic [7:0] d);
        @(posedge CLK);
        REQ_VALID <= 1'b1;
        REQ_KIND <= k;
        REQ_MODE <= md;
        REQ_PTR <= pt;
        REQ_ADDR <= a;
        REQ_DISP <= a[5:0];
        REQ_BIT <= d[2:0];
        REQ_WDATA <= d;
        @(negedge CLK);
        while (!REQ_READY) @(negedge CLK);
        @(posedge CLK);
        REQ_VALID <= 1'b0;
        lo = 0;
        do begin
            @(negedge CLK);
            if (RSP_VALID) begin
                q = RSP_DATA;
                s = RSP_SKIP;
            end
            lo++;
        end while (!REQ_READY && lo < 9);
    endtask
    task automatic t_gp;
        rq(dsd_pkg::K_OUT, 16'h001e, 8'h5a);
        rq(dsd_pkg::K_BSET, 16'h001e, 8'h00);
        rq(dsd_pkg::K_BCLR, 16'h001e, 8'h01);
        rq(dsd_pkg::K_SKIP_SET, 16'h001e, 8'h03);
        c8({7'h0, s}, 8'h01);
        rq(dsd_pkg::K_LOAD, 16'h003e, 8'h00);
        c8(q, 8'h59);
        rq(dsd_pkg::K_OUT, 16'h002a, 8'h00);
        rq(dsd_pkg::K_BSET, 16'h002a, 8'h00);
        rq(dsd_pkg::K_IN, 16'h002a, 8'h00);
        c8(q, 8'h00);
    endtask
    task automatic t_flag;
        @(posedge CLK) FLAG_SET <= 8'h05;
        @(posedge CLK) FLAG_SET <= 8'h00;
        rq(dsd_pkg::K_BCLR, 16'h0015, 8'h02);
        rq(dsd_pkg::K_IN, 16'h0015, 8'h00);
        c8(q, 8'h05);
        rq(dsd_pkg::K_OUT, 16'h0015, 8'h01);
        rq(dsd_pkg::K_IN, 16'h0015, 8'h00);
        c8(q, 8'h04);
        rq(dsd_pkg::K_OUT, 16'h0010, 8'hf0);
        rq(dsd_pkg::K_BSET, 16'h0010, 8'h00);
        rq(dsd_pkg::K_IN, 16'h0010, 8'h00);
        c8(q, 8'hf1);
    endtask
    task automatic t_mem;
        md = dsd_pkg::M_DISP;
        pt = dsd_pkg::P_Y;
        rq(dsd_pkg::K_STORE, 16'h003f, 8'ha5);
        md = dsd_pkg::M_POSTINC;
        pt = dsd_pkg::P_X;
        rq(dsd_pkg::K_STORE, 16'h0000, 8'h3c);
        md = dsd_pkg::M_PREDEC;
        pt = dsd_pkg::P_Z;
        rq(dsd_pkg::K_LOAD, 16'h0000, 8'h00);
        c8(q, 8'ha5);
        md = dsd_pkg::M_DIRECT;
        rq(dsd_pkg::K_LOAD, 16'h0200, 8'h00);
        c8(q, 8'h3c);
        cn(lo, 2);
        rq(dsd_pkg::K_STORE, 16'h0005, 8'h77);
        rq(dsd_pkg::K_LOAD, 16'h0005, 8'h00);
        c8(q, 8'h77);
        rq(dsd_pkg::K_STORE, 16'h0080, 8'h12);
        rq(dsd_pkg::K_LOAD, 16'h0080, 8'h00);
        c8(q, 8'h12);
        rq(dsd_pkg::K_STORE, 16'h0300, 8'h66);
        rq(dsd_pkg::K_LOAD, 16'h0300, 8'h00);
        c8(q, 8'h00);
    endtask
    task automatic t_nv;
        rq(dsd_pkg::K_OUT, 16'h001f, 8'h02);
        c8({7'h0, NV_BUSY}, 8'h00);
        rq(dsd_pkg::K_OUT, 16'h0021, 8'h10);
        rq(dsd_pkg::K_OUT, 16'h0022, 8'h00);
        rq(dsd_pkg::K_OUT, 16'h0020, 8'h99);
        rq(dsd_pkg::K_OUT, 16'h001f, 8'h04);
        rq(dsd_pkg::K_OUT, 16'h001f, 8'h02);
        cn(lo, 4);
        c8({7'h0, NV_BUSY}, 8'h01);
        do rq(dsd_pkg::K_IN, 16'h001f, 8'h00); while (q[1]);
        rq(dsd_pkg::K_OUT, 16'h0020, 8'h00);
        rq(dsd_pkg::K_OUT, 16'h001f, 8'h01);
        cn(lo, 6);
        rq(dsd_pkg::K_IN, 16'h0020, 8'h00);
        c8(q, 8'h99);
        rq(dsd_pkg::K_OUT, 16'h001f, 8'h04);
        repeat (4) @(posedge CLK);
        rq(dsd_pkg::K_OUT, 16'h001f, 8'h02);
        c8({7'h0, NV_BUSY}, 8'h00);
        rq(dsd_pkg::K_OUT, 16'h001f, 8'h04);
        rq(dsd_pkg::K_OUT, 16'h001f, 8'h02);
        @(posedge CLK) SYS_RST <= 1'b1;
        @(posedge CLK) SYS_RST <= 1'b0;
        c8({7'h0, NV_BUSY}, 8'h01);
    endtask
    task automatic conclude;
        if (bad_count == 0 && n_tests > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    initial begin
        repeat (6) @(posedge CLK);
        SYS_RST <= 1'b0;
        NV_POR <= 1'b0;
        t_gp;
        t_flag;
        t_mem;
        t_nv;
        conclude;
    end
    // Whole run is well under a thousand cycles
    initial begin
        #200000;
        bad_count++;
        conclude;
    end
endmodule
